//--- rtsp_consts.vh
/*
 constants for the real-time trace status port: status codes, marker codes,
 fifo geometry and byte-count settings. assumes inclusion by rtsp_trace_port.v.
*/
`ifndef RTSP_CONSTS_VH
`define RTSP_CONSTS_VH

// ----------------------------------------------------------------
// status nibble codes
// ----------------------------------------------------------------
`define RTSP_ST_CONT      4'h0
`define RTSP_ST_BEGIN     4'h1
`define RTSP_ST_USER      4'h3
`define RTSP_ST_WDATA     4'h4
`define RTSP_ST_BRANCH    4'h5
`define RTSP_ST_RTE       4'h7
`define RTSP_ST_MARK1     4'h8
`define RTSP_ST_EXC       4'hc
`define RTSP_ST_EMU       4'hd
`define RTSP_ST_STOP      4'he
`define RTSP_ST_HALT      4'hf

// ----------------------------------------------------------------
// instruction classes from the core
// ----------------------------------------------------------------
`define RTSP_IC_NORMAL    3'h0
`define RTSP_IC_BRANCH    3'h1
`define RTSP_IC_RTE       3'h2
`define RTSP_IC_PULSE     3'h3
`define RTSP_IC_WDATA     3'h4
`define RTSP_IC_USER      3'h5

// ----------------------------------------------------------------
// fifo and byte counts
// ----------------------------------------------------------------
`define RTSP_FIFO_DEPTH   2
`define RTSP_DATA_W       32
`define RTSP_BCNT_W       2
`define RTSP_NIB_W        4
`define RTSP_ADDR_SHIFT   1
`define RTSP_BT_2B        2'h1
`define RTSP_BT_3B        2'h2
`define RTSP_BT_4B        2'h3
`define RTSP_BT_OFF       2'h0

`endif

//--- rtsp_probe.sv
/* trace probe model: makes the free-running trace clock and logs the pins.
   assumes the port moves its pins a few mclk after each trace clock rise. */
`timescale 1ns/1ps
`default_nettype none
module rtsp_probe (
   // link clock and trace pins
   output var logic        trace_clock,
   input  wire logic [3:0] status_nib,
   input  wire logic [3:0] data_nib
);
   logic [7:0] log_q [$];
   initial begin
      trace_clock = 1'b0;
      #3;
      forever #40 trace_clock = ~trace_clock;
   end
   // sampled at the rise, long after the last tick settled; the log feeds the testbench checks
   always @(posedge trace_clock) log_q.push_back({status_nib, data_nib});
endmodule // rtsp_probe
`default_nettype wire

//--- rtsp_sva.sv
/* pin checker for rtsp_trace_port, bound to every instance.
   assumes trace_clock spans 8 mclk and at most one core mode level is high at a time. */
`timescale 1ns/1ps
`default_nettype none
module rtsp_sva (
   // clock and reset
   input wire logic       mclk,
   input wire logic       nrst,
   // core side
   input wire logic       instr_start,
   input wire logic       data_capture,
   input wire logic       exc_active,
   input wire logic       emu_exc_active,
   input wire logic       stopped,
   input wire logic       halted,
   // port outputs
   input wire logic       core_stall,
   input wire logic [3:0] processor_status_nibble,
   input wire logic [3:0] debug_data_nibble
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire [3:0] st = processor_status_nibble;
   wire [3:0] md = {exc_active, emu_exc_active, stopped, halted};
   // a marker is followed one tick later by data, never by a second marker
   sequence s_mark; md == 4'h0 && $changed(st) && st[3:2] == 2'b10; endsequence
   sequence s_next; ##9 st[3:2] != 2'b10; endsequence
   property p_rsvd; st != 4'h2 && st != 4'h6; endproperty
   property p_exc; md == 4'h8 && $past(md, 10) == 4'h8 |-> st == 4'hc; endproperty
   property p_emu; md == 4'h4 && $past(md, 10) == 4'h4 |-> st == 4'hd; endproperty
   property p_stop; md == 4'h2 && $past(md, 10) == 4'h2 |-> st == 4'he; endproperty
   property p_halt; md == 4'h1 && $past(md, 10) == 4'h1 |-> st == 4'hf; endproperty
   property p_mark; s_mark |-> s_next; endproperty
   property p_hold; $changed(st) |=> $stable(st)[*6]; endproperty
   property p_stall; core_stall |-> data_capture || instr_start; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved status");
   a_exc: assert property (p_exc) else $error("no 0xc");
   a_emu: assert property (p_emu) else $error("no 0xd");
   a_stop: assert property (p_stop) else $error("no 0xe");
   a_halt: assert property (p_halt) else $error("no 0xf");
   a_mark: assert property (p_mark) else $error("marker twice");
   a_hold: assert property (p_hold) else $error("status short");
   a_stall: assert property (p_stall) else $error("stall no cause");
endmodule // rtsp_sva
bind rtsp_trace_port rtsp_sva u_sva (.*);
`default_nettype wire

//--- rtsp_trace_port.v
/*
 real-time trace status port: status nibble encoder plus a two-entry 32-bit
 fifo shifting captured values out on the debug data nibble.
 assumes: core events arrive on mclk; trace_clock is a free-running pin-rate
 clock from outside, sampled here by mclk; trace pins change a few mclk after its rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtsp_consts.vh"

module rtsp_trace_port #(
   parameter DEPTH = `RTSP_FIFO_DEPTH,
   parameter DW    = `RTSP_DATA_W
) (
   // clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // trace pin clock from outside
   input  wire        trace_clock,
   // core events, one-cycle pulses unless noted
   input  wire        instr_start,
   input  wire [2:0]  instr_class,
   input  wire        branch_taken,
   input  wire        branch_variant,
   input  wire [31:0] branch_target,
   input  wire        data_capture,
   input  wire [31:0] data_value,
   input  wire [1:0]  data_bytes_m1,
   input  wire        pc_sync_request,
   // core modes, levels
   input  wire        exc_active,
   input  wire        emu_exc_active,
   input  wire        stopped,
   input  wire        halted,
   // configuration: 0 off, 1..3 = 2..4 bytes
   input  wire [1:0]  branch_target_display_field,
   // core stall
   output wire        core_stall,
   // trace pins
   output reg  [3:0]  processor_status_nibble,
   output reg  [3:0]  debug_data_nibble
);

   // ----------------------------------------------------------------
   // trace clock edge detection
   // ----------------------------------------------------------------
   reg  tclk_s1_q;
   reg  tclk_s2_q;
   reg  tclk_s3_q;
   wire tick;

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tclk_s1_q <= 1'b0;
         tclk_s2_q <= 1'b0;
         tclk_s3_q <= 1'b0;
      end else begin
         tclk_s1_q <= trace_clock;
         tclk_s2_q <= tclk_s1_q;
         tclk_s3_q <= tclk_s2_q;
      end
   end

   // one mclk pulse per rising trace clock edge: pins advance on it
   assign tick = tclk_s2_q & ~tclk_s3_q;

   // ----------------------------------------------------------------
   // capture decision
   // ----------------------------------------------------------------
   reg         cap_req;
   reg  [31:0] cap_val;
   reg  [1:0]  cap_bm1;
   reg  [3:0]  evt_code;

   always @* begin
      cap_req = 1'b0;
      cap_val = data_value;
      cap_bm1 = data_bytes_m1;
      if (instr_start && branch_taken && branch_variant &&
          branch_target_display_field != `RTSP_BT_OFF) begin
         cap_req = 1'b1;
         cap_val = branch_target >> `RTSP_ADDR_SHIFT;
         cap_bm1 = branch_target_display_field;
      end else if (data_capture) begin
         cap_req = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // fifo
   // ----------------------------------------------------------------
   reg  [DW-1:0] fifo_val_q [0:DEPTH-1];
   reg  [1:0]    fifo_bm1_q [0:DEPTH-1];
   reg           wr_ptr_q;
   reg           rd_ptr_q;
   reg  [1:0]    count_q;
   wire          full;
   wire          empty;
   wire          push;
   wire          pop;

   assign full       = (count_q == DEPTH[1:0]);
   assign empty      = (count_q == 2'h0);
   assign core_stall = cap_req & full;
   assign push       = cap_req & ~full;

   // ----------------------------------------------------------------
   // fifo head and mode summary
   // ----------------------------------------------------------------
   wire [DW-1:0] head_val;
   wire [1:0]    head_bm1;
   wire          mode_any;
   wire          mark_go;
   reg  [1:0]    count_d;

   // the entry under the read pointer is what the next marker announces
   assign head_val = fifo_val_q[rd_ptr_q];
   assign head_bm1 = fifo_bm1_q[rd_ptr_q];

   // a mode code owns the status pins, so no marker may start under it
   assign mode_any = halted | stopped | emu_exc_active | exc_active;

   // fill level: a push and a pop in one cycle leave it unchanged
   always @* begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 2'h1;
      end else if (pop && !push) begin
         count_d = count_q - 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // shifter: marker then nibbles, one per trace cycle
   // ----------------------------------------------------------------
   localparam SH_IDLE = 2'h0;
   localparam SH_MARK = 2'h1;
   localparam SH_DATA = 2'h2;

   reg  [1:0]  sh_state_q;
   reg  [1:0]  sh_state_d;
   reg  [31:0] sh_data_q;
   reg  [31:0] sh_data_d;
   reg  [2:0]  sh_left_q;
   reg  [2:0]  sh_left_d;
   reg  [3:0]  debug_data_nibble_d;

   // marker and pop go together: a marker hidden behind a mode code would
   // leave the probe unable to frame the nibbles that follow it
   assign mark_go = tick & ~empty & ~mode_any & (sh_state_q == SH_IDLE);
   assign pop     = mark_go;

   integer i;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
         for (i = 0; i < DEPTH; i = i + 1) begin
            fifo_val_q[i] <= {DW{1'b0}};
            fifo_bm1_q[i] <= 2'h0;
         end
      end else begin
         if (push) begin
            fifo_val_q[wr_ptr_q] <= cap_val;
            fifo_bm1_q[wr_ptr_q] <= cap_bm1;
            wr_ptr_q             <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         count_q <= count_d;
      end
   end

   always @* begin
      sh_state_d = sh_state_q;
      sh_data_d  = sh_data_q;
      sh_left_d  = sh_left_q;
      debug_data_nibble_d    = debug_data_nibble;
      case (sh_state_q)
         SH_IDLE: begin
            if (mark_go) begin
               sh_data_d  = head_val;
               sh_left_d  = {head_bm1, 1'b1};                      // nibbles minus one
               sh_state_d = SH_MARK;
            end
         end
         SH_MARK: begin
            if (tick) begin
               debug_data_nibble_d    = sh_data_q[3:0];
               sh_data_d  = sh_data_q >> `RTSP_NIB_W;
               sh_state_d = SH_DATA;
            end
         end
         SH_DATA: begin
            if (tick && sh_left_q == 3'h0) begin
               sh_state_d = SH_IDLE;
            end else if (tick) begin
               debug_data_nibble_d    = sh_data_q[3:0];
               sh_data_d  = sh_data_q >> `RTSP_NIB_W;
               sh_left_d  = sh_left_q - 3'h1;
            end
         end
         default: begin
            sh_state_d = SH_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // shifter registers
   // ----------------------------------------------------------------
   // data pins hold the last nibble between values
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sh_state_q        <= SH_IDLE;
         sh_data_q         <= 32'h0;
         sh_left_q         <= 3'h0;
         debug_data_nibble <= 4'h0;
      end else begin
         sh_state_q        <= sh_state_d;
         sh_data_q         <= sh_data_d;
         sh_left_q         <= sh_left_d;
         debug_data_nibble <= debug_data_nibble_d;
      end
   end

   // ----------------------------------------------------------------
   // status encoding
   // ----------------------------------------------------------------
   // instruction events are latched until the next trace tick so a
   // single-mclk event is not lost between slower pin updates
   reg  [3:0] pend_q;
   reg  [3:0] pend_d;
   reg        pend_v_q;
   reg        pend_v_d;

   always @* begin
      evt_code = `RTSP_ST_CONT;
      if (pc_sync_request) begin
         evt_code = `RTSP_ST_BRANCH;
      end else if (instr_start && !core_stall) begin
         if (branch_taken) begin
            evt_code = `RTSP_ST_BRANCH;
         end else if (instr_class == `RTSP_IC_RTE) begin
            evt_code = `RTSP_ST_RTE;
         end else if (instr_class == `RTSP_IC_PULSE || instr_class == `RTSP_IC_WDATA) begin
            evt_code = `RTSP_ST_WDATA;
         end else if (instr_class == `RTSP_IC_USER) begin
            evt_code = `RTSP_ST_USER;
         end else begin
            evt_code = `RTSP_ST_BEGIN;
         end
      end
   end

   // ----------------------------------------------------------------
   // pending event latch
   // ----------------------------------------------------------------
   // a marker tick leaves the event pending so that it shows one tick later
   always @* begin
      pend_d   = pend_q;
      pend_v_d = pend_v_q;
      if (evt_code != `RTSP_ST_CONT) begin
         pend_d   = evt_code;
         pend_v_d = 1'b1;
      end else if (tick && !mark_go) begin
         pend_v_d = 1'b0;
      end
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pend_q   <= `RTSP_ST_CONT;
         pend_v_q <= 1'b0;
      end else begin
         pend_q   <= pend_d;
         pend_v_q <= pend_v_d;
      end
   end

   // ----------------------------------------------------------------
   // status next value
   // ----------------------------------------------------------------
   reg  [3:0] status_d;

   // mode codes win; a marker beats a pending event, which then waits a tick
   always @* begin
      status_d = processor_status_nibble;
      if (tick) begin
         if (halted) begin
            status_d = `RTSP_ST_HALT;
         end else if (stopped) begin
            status_d = `RTSP_ST_STOP;
         end else if (emu_exc_active) begin
            status_d = `RTSP_ST_EMU;
         end else if (exc_active) begin
            status_d = `RTSP_ST_EXC;
         end else if (mark_go) begin
            status_d = `RTSP_ST_MARK1 | {2'b00, head_bm1};
         end else if (pend_v_q) begin
            status_d = pend_q;
         end else begin
            status_d = `RTSP_ST_CONT;
         end
      end
   end

   // ----------------------------------------------------------------
   // status register
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         processor_status_nibble <= `RTSP_ST_CONT;
      end else begin
         processor_status_nibble <= status_d;
      end
   end

endmodule // rtsp_trace_port
`default_nettype wire

//--- testbench.sv
/* testbench for rtsp_trace_port: each scenario task judges the probe's pin log.
   assumes rtsp_probe logs one status/data pair per trace clock. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk = 0, nrst = 0, instr_start = 0, tk = 0, vr = 0, cap = 0, sync = 0;
   logic [2:0]  cls = 0;
   logic [1:0]  bm1 = 0, btd = 0;
   logic [3:0]  md = 0;
   logic [31:0] tgt = 0, dv = 0;
   wire logic   stall, tclk;
   wire [3:0]   st, dd;
   int          n_mismatch = 0, num_checks = 0, cyc = 0;
   rtsp_trace_port dut (.mclk(mclk), .nrst(nrst), .trace_clock(tclk), .instr_start(instr_start),
      .instr_class(cls), .branch_taken(tk), .branch_variant(vr), .branch_target(tgt), .data_capture(cap),
      .data_value(dv), .data_bytes_m1(bm1), .pc_sync_request(sync), .exc_active(md[3]), .emu_exc_active(md[2]),
      .stopped(md[1]), .halted(md[0]), .branch_target_display_field(btd), .core_stall(stall),
      .processor_status_nibble(st), .debug_data_nibble(dd));
   rtsp_probe prb (.trace_clock(tclk), .status_nib(st), .data_nib(dd));
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk4(input logic [3:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t pin %h want %h", $time, got, exp);
      end
   endtask
   task automatic req(input logic i, d, input logic [2:0] c, input logic [1:0] tv, b, input logic [31:0] x,
                      output logic s);
      @(negedge mclk);
      {instr_start, cap, cls, tk, vr, bm1, tgt, dv} = {i, d, c, tv, b, x, x};
      #1 s = stall;
      // a refused request is held and retried until the fifo frees
      for (int k = 0; k < 400 && stall; k++) @(posedge mclk) #1;
      @(posedge mclk);
      @(negedge mclk);
      {instr_start, cap, tk, vr} = 4'h0;
   endtask
   function automatic int find(input logic [3:0] code);
      find = -1;
      foreach (prb.log_q[i]) if (find < 0 && prb.log_q[i][7:4] === code) find = i;
   endfunction
   task automatic chk_seq(input logic [3:0] mk, input logic [31:0] x, input int n);
      int i;
      i = find(mk);
      chk4(i < 0 ? 4'h2 : mk, mk);
      for (int j = 0; j < n && i >= 0 && i + j + 1 < prb.log_q.size(); j++)
         chk4(prb.log_q[i + j + 1][3:0], x[4 * j +: 4]);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         @(negedge mclk) md = 4'h8 >> m;
         repeat (3) @(posedge tclk);
         chk4(prb.log_q[$][7:4], 4'hc + m[3:0]);
         @(negedge mclk) md = 4'h0;
         repeat (2) @(posedge tclk);
      end
   endtask
   task automatic t_events;
      logic [2:0] c[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h1};
      logic [3:0] e[6] = '{4'h1, 4'h7, 4'h4, 4'h3, 4'h5, 4'h5};
      logic s;
      for (int k = 0; k < 6; k++) begin
         prb.log_q.delete();
         if (k < 5) req(1'b1, 1'b0, c[k], {k == 4, 1'b0}, 2'h0, 32'h0, s);
         else begin
            @(negedge mclk) sync = 1'b1;
            @(negedge mclk) sync = 1'b0;
         end
         repeat (4) @(posedge tclk);
         chk4(find(e[k]) < 0 ? 4'h2 : e[k], e[k]);
         chk4(prb.log_q[$][7:4], 4'h0);
      end
   endtask
   task automatic t_branch;
      logic s;
      for (int f = 0; f < 5; f++) begin
         prb.log_q.delete();
         @(negedge mclk) btd = (f > 3) ? 2'h3 : f[1:0];
         req(1'b1, 1'b0, 3'h1, {1'b1, f < 4}, 2'h0, 32'h2468_ace0, s);
         repeat (12) @(posedge tclk);
         if (f == 0 || f == 4) chk4(find(4'hb) < 0 ? 4'h0 : 4'hb, 4'h0);
         else chk_seq(4'h8 + f[3:0], 32'h1234_5670, 2 * f + 2);
      end
   endtask
   task automatic t_stall;
      logic [4:0] s;
      prb.log_q.delete();
      req(1'b1, 1'b1, 3'h4, 2'h0, 2'h3, 32'h8765_4321, s[0]);
      req(1'b0, 1'b1, 3'h0, 2'h0, 2'h0, 32'h0000_00a5, s[1]);
      req(1'b0, 1'b1, 3'h0, 2'h0, 2'h1, 32'h0000_beef, s[2]);
      req(1'b0, 1'b1, 3'h0, 2'h0, 2'h1, 32'h0000_cafe, s[3]);
      req(1'b1, 1'b0, 3'h0, 2'h0, 2'h0, 32'h0, s[4]);
      repeat (45) @(posedge tclk);
      chk4({2'h0, s[1:0]}, 4'h0);
      chk4({3'h0, |s[3:2]}, 4'h1);
      chk4(find(4'h4) < 0 ? 4'h2 : 4'h4, 4'h4);
      chk_seq(4'hb, 32'h8765_4321, 8);
      chk_seq(4'h8, 32'h0000_00a5, 2);
      chk4(find(4'h1) < 0 ? 4'h2 : 4'h1, 4'h1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk) nrst = 1'b1;
      t_modes();
      t_events();
      t_branch();
      t_stall();
      stop_test();
   end
endmodule // testbench
`default_nettype wire
